// ===== rtl/arc_rx_checker.sv
/*
  Receive-side checker and event-code reporter for asynchronous packets.
  Classifies each received packet from its header summary and end status,
  produces a keep/pad/truncate verdict for the FIFO write path, latches the
  header for software, and reports event codes including packet-sent.
  Assumes the receiver core delivers header summary and end status as
  single-cycle strobes on the link clock, header before end.
*/
`timescale 1ns/1ps
module arc_rx_checker
  import arc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic hdr_valid_i,
  input wire arc_pkg::arc_hdr_info_t hdr_info_i,
  input wire logic [31:0] hdr_word_i [4],
  input wire logic end_valid_i,
  input wire arc_pkg::arc_end_info_t end_info_i,
  input wire logic pad_ones_i,
  input wire logic [15:0] bank_size_i,
  input wire logic tx_done_i,
  input wire logic ev_ack_i,
  input wire logic [1:0] hdr_sel_i,
  output arc_pkg::arc_verdict_t verdict_o,
  output logic verdict_valid_o,
  output logic [31:0] pad_word_o,
  output logic [31:0] hdr_view_o,
  output logic ev_pending_o,
  output logic [7:0] ev_code_o,
  output logic [2:0] ev_category_o,
  output logic ev_overrun_o
);
  import arc_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // Async assert, synchronous release through two flops
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Header capture
  // ----------------------------------------------------------------
  arc_hdr_info_t hdr;
  logic hdr_seen;
  logic [31:0] hdr_shadow [4];
  logic [31:0] hdr_view_reg [4];

  // Summary latched for the end-of-packet decision
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hdr <= '0;
      hdr_seen <= 1'b0;
    end else if (hdr_valid_i) begin
      hdr <= hdr_info_i;
      hdr_seen <= 1'b1;
    end else if (end_valid_i) begin
      hdr_seen <= 1'b0;
    end
  end

  // Shadow words wait for the verdict so a discarded packet never shows
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        hdr_shadow[i] <= ARC_HDR_RST;
      end
    end else if (hdr_valid_i) begin
      for (int i = 0; i < 4; i++) begin
        hdr_shadow[i] <= hdr_word_i[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Classification
  // ----------------------------------------------------------------
  arc_verdict_t next_verdict;
  logic [7:0] next_ev_a;
  logic next_ev_a_valid;
  logic [7:0] next_ev_b;
  logic next_ev_b_valid;
  logic good_rx;

  function automatic logic len_invalid(input arc_hdr_info_t h, input logic [15:0] bank);
    if (h.to_bank_fifo) begin
      len_invalid = h.data_length > bank;
    end else begin
      len_invalid = h.data_length > ARC_ASYNC_MAX_LEN;
    end
  endfunction

  // Error priority: header faults discard first, then length handling
  always_comb begin
    next_verdict = '0;
    next_verdict.pad_ones = pad_ones_i;
    next_verdict.store_length = hdr.data_length;
    next_ev_a = ARC_EV_NONE;
    next_ev_a_valid = 1'b0;
    next_ev_b = ARC_EV_NONE;
    next_ev_b_valid = 1'b0;
    good_rx = 1'b0;
    if (!end_info_i.end_found && (end_info_i.in_header || !hdr_seen)) begin
      next_ev_a = ARC_EV_NO_END;
      next_ev_a_valid = 1'b1;
    end else if (end_info_i.hdr_crc_bad) begin
      next_ev_a = ARC_EV_HDR_CRC;
      next_ev_a_valid = 1'b1;
    end else if (hdr.format_bad) begin
      next_ev_a = ARC_EV_FORMAT;
      next_ev_a_valid = 1'b1;
    end else if (hdr.has_data && len_invalid(hdr, bank_size_i)) begin
      next_ev_a = ARC_EV_LEN_INVALID;
      next_ev_a_valid = 1'b1;
      next_verdict.ack_busy = hdr.ack_due;
    end else if (hdr.to_self) begin
      next_verdict.keep = 1'b1;
      if (hdr.has_data && end_info_i.data_count < hdr.data_length) begin
        next_verdict.pad = 1'b1;
        next_ev_a = end_info_i.end_found ? ARC_EV_LEN_SHORT : ARC_EV_NO_END;
        next_ev_a_valid = 1'b1;
      end else if (hdr.has_data && end_info_i.data_count > hdr.data_length) begin
        next_verdict.truncate = 1'b1;
        next_ev_a = end_info_i.end_found ? ARC_EV_LEN_LONG : ARC_EV_NO_END;
        next_ev_a_valid = 1'b1;
      end else if (!end_info_i.end_found) begin
        next_ev_a = ARC_EV_NO_END;
        next_ev_a_valid = 1'b1;
      end else if (end_info_i.data_crc_bad) begin
        next_ev_a = ARC_EV_DATA_CRC;
        next_ev_a_valid = 1'b1;
      end else begin
        good_rx = 1'b1;
        if (hdr.dest_offset == ARC_OFS_A) begin
          next_ev_a = ARC_EV_RX_OFS_A;
        end else if (hdr.dest_offset == ARC_OFS_B) begin
          next_ev_a = ARC_EV_RX_OFS_B;
        end else if (hdr.has_data || hdr.quadlet_payload) begin
          next_ev_a = ARC_EV_RX_FIFO;
        end else begin
          next_ev_a = ARC_EV_RX_NODATA;
        end
        next_ev_a_valid = 1'b1;
      end
    end
    next_ev_b = ARC_EV_TX_SENT;
    next_ev_b_valid = tx_done_i;
  end

  // ----------------------------------------------------------------
  // Verdict and header view
  // ----------------------------------------------------------------
  // Verdict is registered one cycle after the end strobe
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      verdict_o <= '0;
      verdict_valid_o <= 1'b0;
      pad_word_o <= ARC_PAD_ZERO;
    end else begin
      verdict_valid_o <= end_valid_i;
      if (end_valid_i) begin
        verdict_o <= next_verdict;
        pad_word_o <= pad_ones_i ? ARC_PAD_ONE : ARC_PAD_ZERO;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        hdr_view_reg[i] <= ARC_HDR_RST;
      end
    end else if (end_valid_i && next_verdict.keep) begin
      for (int i = 0; i < 4; i++) begin
        hdr_view_reg[i] <= hdr_shadow[i];
      end
    end
  end

  // Read mux registered so the view is a clean flop output
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hdr_view_o <= ARC_HDR_RST;
    end else begin
      hdr_view_o <= hdr_view_reg[hdr_sel_i];
    end
  end

  // ----------------------------------------------------------------
  // Event reporting
  // ----------------------------------------------------------------
  // categorised pending code
  arc_event_queue u_queue (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .ev_a_valid_i(end_valid_i && next_ev_a_valid),
    .ev_a_code_i(next_ev_a),
    .ev_b_valid_i(next_ev_b_valid),
    .ev_b_code_i(next_ev_b),
    .ack_i(ev_ack_i),
    .pending_o(ev_pending_o),
    .code_o(ev_code_o),
    .category_o(ev_category_o),
    .overrun_o(ev_overrun_o)
  );

endmodule

// ===== rtl/arc_pkg.sv
/*
  Package for the asynchronous receive checker and event-code reporter.
  Holds event codes, mask categories, special offsets, limits and the
  packed structs that carry packet descriptors between the link core and
  this block. Assumes a single link-layer clock domain.
*/
package arc_pkg;

  // ----------------------------------------------------------------
  // Event codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ARC_EV_RX_FIFO = 8'h21;
  localparam logic [7:0] ARC_EV_RX_NODATA = 8'h22;
  localparam logic [7:0] ARC_EV_RX_OFS_A = 8'h23;
  localparam logic [7:0] ARC_EV_RX_OFS_B = 8'h24;
  localparam logic [7:0] ARC_EV_LEN_SHORT = 8'h31;
  localparam logic [7:0] ARC_EV_LEN_LONG = 8'h32;
  localparam logic [7:0] ARC_EV_FORMAT = 8'h33;
  localparam logic [7:0] ARC_EV_NO_END = 8'h34;
  localparam logic [7:0] ARC_EV_HDR_CRC = 8'h35;
  localparam logic [7:0] ARC_EV_DATA_CRC = 8'h36;
  localparam logic [7:0] ARC_EV_LEN_INVALID = 8'h37;
  localparam logic [7:0] ARC_EV_TX_SENT = 8'h61;
  localparam logic [7:0] ARC_EV_NONE = 8'h00;

  // ----------------------------------------------------------------
  // Mask categories (one-hot): C receive, D receive error, G sent
  // ----------------------------------------------------------------
  localparam logic [2:0] ARC_CAT_NONE = 3'h0;
  localparam logic [2:0] ARC_CAT_RX = 3'h1;
  localparam logic [2:0] ARC_CAT_RX_ERR = 3'h2;
  localparam logic [2:0] ARC_CAT_TX = 3'h4;

  // ----------------------------------------------------------------
  // Special destination offsets and length limits
  // ----------------------------------------------------------------
  localparam logic [47:0] ARC_OFS_A = 48'hffff_f000_1008;
  localparam logic [47:0] ARC_OFS_B = 48'hffff_f000_1010;
  localparam logic [15:0] ARC_ASYNC_MAX_LEN = 16'h0080;  // 128 bytes allowed
  localparam logic [15:0] ARC_BANK_SIZE_RST = 16'h0400;
  localparam logic [3:0] ARC_HDR_WORDS = 4'h4;
  localparam logic [31:0] ARC_HDR_RST = 32'h0000_0000;

  // Pad fill words
  localparam logic [31:0] ARC_PAD_ZERO = 32'h0000_0000;
  localparam logic [31:0] ARC_PAD_ONE = 32'hffff_ffff;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Header summary, presented once the header has passed its CRC slot
  typedef struct packed {
    logic to_self;
    logic has_data;
    logic quadlet_payload;  // Quadlet write request / quadlet read response
    logic to_bank_fifo;
    logic format_bad;
    logic [47:0] dest_offset;
    logic [15:0] data_length;  // Bytes
    logic ack_due;
  } arc_hdr_info_t;

  // End-of-packet status from the receiver
  typedef struct packed {
    logic end_found;
    logic in_header;  // Packet ended while header still arriving
    logic hdr_crc_bad;
    logic data_crc_bad;
    logic [15:0] data_count;  // Bytes actually received
  } arc_end_info_t;

  // Verdict that steers the FIFO write path
  typedef struct packed {
    logic keep;
    logic pad;
    logic pad_ones;
    logic truncate;
    logic ack_busy;
    logic [15:0] store_length;
  } arc_verdict_t;

endpackage

// ===== rtl/arc_event_queue.sv
/*
  Event pending register for the checker. Holds one eight-bit event code
  with its mask category until software acknowledges it, and queues the
  next event in a one-deep holding slot.
  Assumes acknowledge arrives on the same clock as the events.
*/
`timescale 1ns/1ps
module arc_event_queue
  import arc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ev_a_valid_i,
  input wire logic [7:0] ev_a_code_i,
  input wire logic ev_b_valid_i,
  input wire logic [7:0] ev_b_code_i,
  input wire logic ack_i,
  output logic pending_o,
  output logic [7:0] code_o,
  output logic [2:0] category_o,
  output logic overrun_o
);
  import arc_pkg::*;

  logic [7:0] hold_code;
  logic hold_valid;

  // ----------------------------------------------------------------
  // Category decode
  // ----------------------------------------------------------------
  // separate mask categories
  function automatic logic [2:0] cat_of(input logic [7:0] c);
    if (c[7:4] == 4'h2) begin
      cat_of = ARC_CAT_RX;
    end else if (c[7:4] == 4'h3) begin
      cat_of = ARC_CAT_RX_ERR;
    end else if (c == ARC_EV_TX_SENT) begin
      cat_of = ARC_CAT_TX;
    end else begin
      cat_of = ARC_CAT_NONE;
    end
  endfunction

  // Front slot: a new event wins over an acknowledge in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pending_o <= 1'b0;
      code_o <= ARC_EV_NONE;
      category_o <= ARC_CAT_NONE;
    end else if (!pending_o || ack_i) begin
      if (hold_valid) begin
        pending_o <= 1'b1;
        code_o <= hold_code;
        category_o <= cat_of(hold_code);
      end else if (ev_a_valid_i) begin
        pending_o <= 1'b1;
        code_o <= ev_a_code_i;
        category_o <= cat_of(ev_a_code_i);
      end else if (ev_b_valid_i) begin
        pending_o <= 1'b1;
        code_o <= ev_b_code_i;
        category_o <= cat_of(ev_b_code_i);
      end else begin
        pending_o <= 1'b0;
      end
    end
  end

  // Holding slot; only one extra event fits, further ones flag overrun.
  // An older held code is never overwritten, so report order is kept.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_valid <= 1'b0;
      hold_code <= ARC_EV_NONE;
      overrun_o <= 1'b0;
    end else if (!pending_o || ack_i) begin
      if (hold_valid) begin
        // Front takes the held code, the first new event moves up
        hold_valid <= ev_a_valid_i || ev_b_valid_i;
        hold_code <= ev_a_valid_i ? ev_a_code_i : ev_b_code_i;
        overrun_o <= overrun_o | (ev_a_valid_i & ev_b_valid_i);
      end else begin
        // Front takes a single event itself; b waits only when both come
        hold_valid <= ev_a_valid_i && ev_b_valid_i;
        hold_code <= ev_b_code_i;
      end
    end else if (!hold_valid) begin
      hold_valid <= ev_a_valid_i || ev_b_valid_i;
      hold_code <= ev_a_valid_i ? ev_a_code_i : ev_b_code_i;
      overrun_o <= overrun_o | (ev_a_valid_i & ev_b_valid_i);
    end else begin
      overrun_o <= overrun_o | ev_a_valid_i | ev_b_valid_i;
    end
  end

endmodule

// ===== verif/arc_rx_chk.sv
/*
  Concurrent checks on the receive checker's ports.
  Assumes one link clock and the active-low asynchronous reset.
*/
`timescale 1ns/1ps
module arc_rx_chk
  import arc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic hdr_valid_i,
  input wire arc_pkg::arc_hdr_info_t hdr_info_i,
  input wire logic end_valid_i,
  input wire arc_pkg::arc_end_info_t end_info_i,
  input wire logic pad_ones_i,
  input wire logic tx_done_i,
  input wire logic ev_ack_i,
  input wire arc_pkg::arc_verdict_t verdict_o,
  input wire logic verdict_valid_o,
  input wire logic [31:0] pad_word_o,
  input wire logic ev_pending_o,
  input wire logic [7:0] ev_code_o,
  input wire logic [2:0] ev_category_o,
  input wire logic ev_overrun_o
);
  logic [15:0] len_q;

  // Header length, kept so padded or cut packets can be tied to it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      len_q <= 16'h0000;
    end else if (hdr_valid_i) begin
      len_q <= hdr_info_i.data_length;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  chk_verdict_time: assert property (verdict_valid_o == $past(end_valid_i))
    else $error("verdict pulse not one cycle after end");
  chk_hcrc_drop: assert property (end_valid_i && end_info_i.hdr_crc_bad |=> !verdict_o.keep)
    else $error("packet with bad header check kept");
  chk_pad_fill: assert property (verdict_valid_o && verdict_o.pad |-> verdict_o.keep
    && verdict_o.pad_ones == $past(pad_ones_i)
    && pad_word_o == (verdict_o.pad_ones ? ARC_PAD_ONE : ARC_PAD_ZERO))
    else $error("pad fill wrong");
  chk_len_store: assert property (verdict_valid_o && (verdict_o.pad || verdict_o.truncate)
    |-> verdict_o.store_length == len_q)
    else $error("stored length differs from header length");
  chk_busy_drop: assert property (verdict_valid_o && verdict_o.ack_busy
    |-> !verdict_o.keep && !verdict_o.pad)
    else $error("busy answer on a kept packet");
  chk_cat_map: assert property (ev_pending_o |-> ev_category_o ==
    (ev_code_o[7:4] == 4'h2 ? ARC_CAT_RX : ev_code_o[7:4] == 4'h3 ? ARC_CAT_RX_ERR : ARC_CAT_TX))
    else $error("category does not match code");
  chk_pend_hold: assert property (ev_pending_o && !ev_ack_i |=> ev_pending_o && $stable(ev_code_o))
    else $error("pending code dropped without acknowledge");
  chk_tx_code: assert property (tx_done_i && !ev_pending_o && !end_valid_i
    |=> ev_pending_o && ev_code_o == ARC_EV_TX_SENT)
    else $error("sent code missing");
  chk_overrun_keep: assert property (ev_overrun_o |=> ev_overrun_o)
    else $error("overrun flag cleared");
endmodule

bind arc_rx_checker arc_rx_chk i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .hdr_valid_i(hdr_valid_i), .hdr_info_i(hdr_info_i), .end_valid_i(end_valid_i),
  .end_info_i(end_info_i), .pad_ones_i(pad_ones_i), .tx_done_i(tx_done_i),
  .ev_ack_i(ev_ack_i), .verdict_o(verdict_o), .verdict_valid_o(verdict_valid_o),
  .pad_word_o(pad_word_o), .ev_pending_o(ev_pending_o), .ev_code_o(ev_code_o),
  .ev_category_o(ev_category_o), .ev_overrun_o(ev_overrun_o));

// ===== verif/arc_far_node.sv
/*
  Far node model: delivers header summary and end status of packets.
  Assumes send is called at a falling clock edge.
*/
`timescale 1ns/1ps
module arc_far_node
  import arc_pkg::*;
(
  input wire logic clk_i,
  output arc_pkg::arc_hdr_info_t hdr_info_o,
  output logic hdr_valid_o,
  output logic [31:0] hdr_word_o [4],
  output arc_pkg::arc_end_info_t end_info_o,
  output logic end_valid_o
);
  initial begin
    hdr_valid_o = 1'b0;
    end_valid_o = 1'b0;
    hdr_info_o = '0;
    end_info_o = '0;
    hdr_word_o = '{default: 32'h0000_0000};
  end

  // Outside a strobe the lines show the inverse, never a stale copy
  task automatic send(input arc_hdr_info_t h, input arc_end_info_t e,
      input logic [31:0] w [4], input int gap);
    if (!e.in_header) begin
      hdr_info_o = h;
      hdr_word_o = w;
      hdr_valid_o = 1'b1;
      @(negedge clk_i);
      hdr_valid_o = 1'b0;
      hdr_info_o = ~h;
      foreach (w[k]) hdr_word_o[k] = ~w[k];
      repeat (gap) @(negedge clk_i);
    end
    end_info_o = e;
    end_valid_o = 1'b1;
    @(negedge clk_i);
    end_valid_o = 1'b0;
    end_info_o = ~e;
  endtask
endmodule

// ===== verif/async_rx_check_event_codes_tb.sv
/*
  Bench for the receive checker: random packets, length limits, sent code
  and overrun. Assumes the far node model and the bound checker.
*/
`timescale 1ns/1ps
module async_rx_check_event_codes_tb;
  import arc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic pad_ones_i = 1'b0;
  logic tx_done_i = 1'b0;
  logic ev_ack_i = 1'b0;
  logic [1:0] hdr_sel_i = 2'h0;
  logic [15:0] bank_size_i = 16'h0100;
  logic hdr_valid_i, end_valid_i, verdict_valid_o, ev_pending_o, ev_overrun_o;
  arc_hdr_info_t hdr_info_i;
  arc_end_info_t end_info_i;
  arc_verdict_t verdict_o;
  logic [31:0] hdr_word_i [4];
  logic [31:0] pad_word_o, hdr_view_o;
  logic [7:0] ev_code_o;
  logic [2:0] ev_category_o;
  int miscompares = 0, checks = 0, cycles = 0, seed = 32'h60a8;

  always #2.5 clk_i = ~clk_i;

  arc_far_node i_node (.clk_i(clk_i), .hdr_info_o(hdr_info_i), .hdr_valid_o(hdr_valid_i),
    .hdr_word_o(hdr_word_i), .end_info_o(end_info_i), .end_valid_o(end_valid_i));

  arc_rx_checker i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .hdr_valid_i(hdr_valid_i),
    .hdr_info_i(hdr_info_i), .hdr_word_i(hdr_word_i), .end_valid_i(end_valid_i),
    .end_info_i(end_info_i), .pad_ones_i(pad_ones_i), .bank_size_i(bank_size_i),
    .tx_done_i(tx_done_i), .ev_ack_i(ev_ack_i), .hdr_sel_i(hdr_sel_i), .verdict_o(verdict_o),
    .verdict_valid_o(verdict_valid_o), .pad_word_o(pad_word_o), .hdr_view_o(hdr_view_o),
    .ev_pending_o(ev_pending_o), .ev_code_o(ev_code_o), .ev_category_o(ev_category_o),
    .ev_overrun_o(ev_overrun_o));

  task automatic results();
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Expected {report, keep, code}, in the order the checks take priority
  function automatic logic [9:0] exp_event(arc_hdr_info_t h, arc_end_info_t e);
    logic big;
    big = h.to_bank_fifo ? h.data_length > bank_size_i : h.data_length > ARC_ASYNC_MAX_LEN;
    if (!e.end_found && e.in_header) return {2'b10, 8'h34};
    if (e.hdr_crc_bad) return {2'b10, 8'h35};
    if (h.format_bad) return {2'b10, 8'h33};
    if (h.has_data && big) return {2'b10, 8'h37};
    if (!h.to_self) return 10'h000;
    if ((h.has_data && e.data_count != h.data_length) || !e.end_found) begin
      return {2'b11, !e.end_found ? 8'h34 : e.data_count < h.data_length ? 8'h31 : 8'h32};
    end
    if (e.data_crc_bad) return {2'b11, 8'h36};
    if (h.dest_offset == ARC_OFS_A) return {2'b11, 8'h23};
    if (h.dest_offset == ARC_OFS_B) return {2'b11, 8'h24};
    return {2'b11, (h.has_data || h.quadlet_payload) ? 8'h21 : 8'h22};
  endfunction

  function automatic void clean(output arc_hdr_info_t h, output arc_end_info_t e,
      input logic [15:0] len);
    h = '0;
    e = '0;
    h.to_self = 1'b1;
    h.has_data = 1'b1;
    h.data_length = len;
    e.end_found = 1'b1;
    e.data_count = len;
  endfunction

  task automatic pulse_tx();
    tx_done_i = 1'b1;
    @(negedge clk_i);
    tx_done_i = 1'b0;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    arc_hdr_info_t h;
    arc_end_info_t e;
    logic [31:0] w [4];
    logic [31:0] r;
    logic [9:0] x;
    logic cut_short, cut_long;
    repeat (2) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    for (int i = 0; i < 90; i++) begin
      r = $random(seed);
      h.to_self = |r[3:2];
      h.has_data = r[0];
      h.quadlet_payload = !r[0] && r[1];
      h.to_bank_fifo = r[4];
      h.format_bad = r[7:5] == 3'h0;
      h.dest_offset = r[9:8] == 2'h0 ? ARC_OFS_A : r[9:8] == 2'h1 ? ARC_OFS_B : {16'hffff, r};
      h.data_length = r[0] ? {9'h000, r[16:10]} : 16'h0000;
      h.ack_due = r[19];
      e.end_found = r[22:20] != 3'h0;
      e.in_header = !e.end_found && r[23];
      e.hdr_crc_bad = r[26:24] == 3'h0;
      e.data_crc_bad = r[29:27] == 3'h0;
      e.data_count = r[31:30] == 2'h0 ? h.data_length + 16'h0004 :
        r[31:30] == 2'h1 ? h.data_length >> 1 : h.data_length;
      // Corner lengths: each FIFO at its limit and one byte past it
      if (i < 4) clean(h, e, (i[1] ? 16'h0100 : ARC_ASYNC_MAX_LEN) + {15'h0000, i[0]});
      if (i < 4) h.to_bank_fifo = i[1];
      h.ack_due = r[19];
      pad_ones_i = r[18];
      foreach (w[k]) w[k] = $random(seed);
      x = exp_event(h, e);
      // Length handling applies only to formats that carry a data length
      cut_short = x[8] && h.has_data && e.data_count < h.data_length;
      cut_long = x[8] && h.has_data && e.data_count > h.data_length;
      i_node.send(h, e, w, i % 4);
      cmp_bit("verdict_valid", 1'b1, verdict_valid_o);
      cmp_bit("keep", x[8], verdict_o.keep);
      cmp_bit("pad", cut_short, verdict_o.pad);
      cmp_bit("truncate", cut_long, verdict_o.truncate);
      cmp_bit("ack_busy", x[7:0] == 8'h37 && h.ack_due, verdict_o.ack_busy);
      cmp_bit("pending", x[9], ev_pending_o);
      if (x[9]) begin
        cmp_word("code", {24'h0, x[7:0]}, {24'h0, ev_code_o});
        ev_ack_i = 1'b1;
        @(negedge clk_i);
        ev_ack_i = 1'b0;
      end
      for (int k = 0; k < 4 && x[8]; k++) begin
        hdr_sel_i = k[1:0];
        @(negedge clk_i);
        cmp_word("hdr_view", w[k], hdr_view_o);
      end
      @(negedge clk_i);
    end
    pulse_tx();
    cmp_bit("pending", 1'b1, ev_pending_o);
    cmp_word("code", 32'h0000_0061, {24'h0, ev_code_o});
    // Packet waits in the hold slot; a third event has nowhere to go
    clean(h, e, 16'h0008);
    i_node.send(h, e, w, 0);
    pulse_tx();
    cmp_bit("overrun", 1'b1, ev_overrun_o);
    cmp_word("code", 32'h0000_0061, {24'h0, ev_code_o});
    ev_ack_i = 1'b1;
    @(negedge clk_i);
    ev_ack_i = 1'b0;
    cmp_word("code", 32'h0000_0021, {24'h0, ev_code_o});
    results();
  end
endmodule
